/* File: verilog/spm_pkg.sv */
// Constants and types for the scan port master shifter
// Behaviour
// - Config bit 3: one initiator, zero target
// - Rate code 1..7 divides master clock
// - Rate field resets to code three
// - Busy flag sets on command write
// - Busy flag clears after last bit
// - Input bits fill capture from bit 0
// - Output word shifts out bit 0 first
// - Both streams run at selected rate
// - Capture and output words RW, reset zero
// - Count field gives count plus one clocks
// - Mode word shifts out bit 0 first
// - Change on falling edge, sample on rising
// - Command ignored while port is target
package spm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CFG = 8'h70;
  localparam logic [7:0] OFS_STAT = 8'h74;
  localparam logic [7:0] OFS_CAP = 8'h78;
  localparam logic [7:0] OFS_OUT = 8'h7c;
  localparam logic [7:0] OFS_MODE = 8'h80;
  localparam logic [7:0] OFS_CMD = 8'h84;
  localparam logic [7:0] OFS_IRQ_ST = 8'h88;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h8c;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CFG_DIR_BIT = 3;
  localparam int LEN_W = 5;
  localparam logic [2:0] RATE_RST = 3'h3;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} spm_state_t;

endpackage

/* File: verilog/spm_shifter.sv */
// Scan port master shifter with AXI4-Lite register slave
`timescale 1ns/1ps
module spm_shifter #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic scan_clk,
  output logic scan_mode,
  output logic scan_data_out,
  input wire logic scan_data_in,
  output logic scan_drive_n,
  output logic irq
);
  import spm_pkg::*;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Half period in master clocks minus one; code 0 runs as code 1
  function automatic logic [6:0] half_load(input logic [2:0] code);
    logic [6:0] r;
    r = 7'h00;
    if (code > 3'h1) begin
      r = 7'((7'h01 << (code - 3'h1)) - 7'h01);
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_CFG) || (a == OFS_STAT) || (a == OFS_CAP) ||
           (a == OFS_OUT) || (a == OFS_MODE) || (a == OFS_CMD) ||
           (a == OFS_IRQ_ST) || (a == OFS_IRQ_MSK);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [2:0] rate_r;
  logic init_r;
  logic [31:0] cap_r;
  logic [31:0] out_r;
  logic [31:0] mode_r;
  logic [LEN_W-1:0] len_r;
  logic [LEN_W-1:0] idx_r;
  logic [6:0] div_r;
  spm_state_t st_r;
  logic sclk_r;
  logic mode_bit_r;
  logic data_bit_r;
  logic din_m_r;
  logic din_s_r;
  logic irq_st_r;
  logic irq_msk_r;
  logic irq_r;
  logic drive_n_r;
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ****************************************
  // Bus decode
  // ****************************************
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_do;
  logic aw_full_nxt;
  logic w_full_nxt;
  logic rvalid_nxt;
  logic wr_cfg;
  logic wr_cap;
  logic wr_out;
  logic wr_mode;
  logic wr_cmd;
  logic wr_ist;
  logic wr_msk;
  logic [7:0] rd_ofs;
  logic [31:0] rd_word;

  assign aw_hs = s_axi_awvalid & awready_r;
  assign w_hs = s_axi_wvalid & wready_r;
  assign ar_hs = s_axi_arvalid & arready_r;
  assign wr_do = aw_full_r & w_full_r & ~bvalid_r;
  assign aw_full_nxt = (aw_full_r | aw_hs) & ~wr_do;
  assign w_full_nxt = (w_full_r | w_hs) & ~wr_do;
  assign rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);
  assign wr_cfg = wr_do & (awa_r == OFS_CFG);
  assign wr_cap = wr_do & (awa_r == OFS_CAP);
  assign wr_out = wr_do & (awa_r == OFS_OUT);
  assign wr_mode = wr_do & (awa_r == OFS_MODE);
  assign wr_cmd = wr_do & (awa_r == OFS_CMD) & ws_r[0];
  assign wr_ist = wr_do & (awa_r == OFS_IRQ_ST) & ws_r[0];
  assign wr_msk = wr_do & (awa_r == OFS_IRQ_MSK) & ws_r[0];
  assign rd_ofs = s_axi_araddr[7:0];

  // ****************************************
  // Shift engine decode
  // ****************************************
  logic busy;
  logic start;
  logic tick;
  logic rise;
  logic fall;
  logic last;
  logic finish;
  logic [LEN_W-1:0] idx_inc;
  logic [6:0] reload;
  logic irq_st_nxt;
  logic irq_msk_nxt;

  assign busy = (st_r != ST_IDLE);
  assign start = wr_cmd & init_r & ~busy;
  assign tick = (div_r == 7'h00);
  assign rise = (st_r == ST_LOW) & tick;
  assign fall = (st_r == ST_HIGH) & tick;
  assign last = (idx_r == len_r);
  assign finish = fall & last;
  assign idx_inc = idx_r + 5'h01;
  assign reload = half_load(rate_r);
  // Hardware set wins over a same-cycle clear
  assign irq_st_nxt = (irq_st_r & ~(wr_ist & wd_r[0])) | finish;
  assign irq_msk_nxt = wr_msk ? wd_r[0] : irq_msk_r;

  assign rd_word =
    (rd_ofs == OFS_CFG) ? {28'h000_0000, init_r, rate_r} :
    (rd_ofs == OFS_STAT) ? {31'h0000_0000, busy} :
    (rd_ofs == OFS_CAP) ? cap_r :
    (rd_ofs == OFS_OUT) ? out_r :
    (rd_ofs == OFS_MODE) ? mode_r :
    (rd_ofs == OFS_IRQ_ST) ? {31'h0000_0000, irq_st_r} :
    (rd_ofs == OFS_IRQ_MSK) ? {31'h0000_0000, irq_msk_r} :
    WORD_RST;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= WORD_RST;
      ws_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r <= ~w_full_nxt;
      if (aw_hs) begin
        awa_r <= s_axi_awaddr[7:0];
      end
      if (w_hs) begin
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awa_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= WORD_RST;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rd_word;
        rresp_r <= mapped(rd_ofs) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_r <= RATE_RST;
      init_r <= 1'b0;
      out_r <= WORD_RST;
      mode_r <= WORD_RST;
      irq_msk_r <= 1'b0;
    end else begin
      if (wr_cfg && ws_r[0]) begin
        rate_r <= wd_r[2:0];
        init_r <= wd_r[CFG_DIR_BIT];
      end
      if (wr_out) begin
        out_r <= merge(out_r, wd_r, ws_r);
      end
      if (wr_mode) begin
        mode_r <= merge(mode_r, wd_r, ws_r);
      end
      irq_msk_r <= irq_msk_nxt;
    end
  end

  // Capture takes software writes first; hardware fills one bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_r <= WORD_RST;
    end else if (wr_cap) begin
      cap_r <= merge(cap_r, wd_r, ws_r);
    end else if (rise) begin
      cap_r[idx_r] <= din_s_r;
    end
  end

  // ****************************************
  // Input synchroniser
  // ****************************************
  // Adds two master clocks of lag; fine at rate code 3 and slower, too slow at codes 1 and 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
    end else begin
      din_m_r <= scan_data_in;
      din_s_r <= din_m_r;
    end
  end

  // ****************************************
  // Shift engine
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      sclk_r <= 1'b0;
      div_r <= 7'h00;
      idx_r <= 5'h00;
      len_r <= 5'h00;
      data_bit_r <= 1'b0;
      mode_bit_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          sclk_r <= 1'b0;
          if (start) begin
            st_r <= ST_LOW;
            len_r <= wd_r[LEN_W-1:0];
            idx_r <= 5'h00;
            div_r <= reload;
            data_bit_r <= out_r[0];
            mode_bit_r <= mode_r[0];
          end
        end
        ST_LOW: begin
          if (tick) begin
            sclk_r <= 1'b1;
            st_r <= ST_HIGH;
            div_r <= reload;
          end else begin
            div_r <= div_r - 7'h01;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            sclk_r <= 1'b0;
            div_r <= reload;
            if (last) begin
              st_r <= ST_IDLE;
            end else begin
              st_r <= ST_LOW;
              idx_r <= idx_inc;
              data_bit_r <= out_r[idx_inc];
              mode_bit_r <= mode_r[idx_inc];
            end
          end else begin
            div_r <= div_r - 7'h01;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt and pin drive
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_r <= 1'b0;
      irq_r <= 1'b0;
      drive_n_r <= 1'b1;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_r <= irq_st_nxt & irq_msk_nxt;
      drive_n_r <= ~init_r;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign scan_clk = sclk_r;
  assign scan_mode = mode_bit_r;
  assign scan_data_out = data_bit_r;
  assign scan_drive_n = drive_n_r;
  assign irq = irq_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [5:0] rises_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      rises_r <= 6'h00;
    end else if (rise) begin
      rises_r <= rises_r + 6'h01;
    end
  end

  sequence s_start;
    start;
  endsequence
  sequence s_last_fall;
    busy && fall && last;
  endsequence

  property p_rate_reset;
    disable iff (1'b0) !aresetn |=> rate_r == RATE_RST && !init_r;
  endproperty
  a_rate_reset: assert property (p_rate_reset)
    else $error("rate or direction wrong after reset");

  property p_target_ignore;
    wr_cmd && !init_r && !busy |=> !busy && !sclk_r;
  endproperty
  a_target_ignore: assert property (p_target_ignore)
    else $error("command started while target");

  property p_busy_set;
    s_start |=> busy ##0 (rd_word[0] || rd_ofs != OFS_STAT);
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy not set by command");

  property p_busy_clear;
    s_last_fall |=> !busy && irq_st_r;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy not cleared after last bit");

  property p_first_bit;
    s_start |=> data_bit_r == $past(out_r[0]) &&
                mode_bit_r == $past(mode_r[0]) && !sclk_r;
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first bit not bit 0");

  property p_next_bit;
    busy && fall && !last |=> mode_bit_r == $past(mode_r[idx_inc]);
  endproperty
  a_next_bit: assert property (p_next_bit)
    else $error("mode bit out of order");

  property p_capture;
    rise && !wr_cap |=> cap_r[$past(idx_r)] == $past(din_s_r);
  endproperty
  a_capture: assert property (p_capture)
    else $error("captured bit misplaced");

  property p_count;
    s_last_fall |-> rises_r == ({1'b0, len_r} + 6'h01);
  endproperty
  a_count: assert property (p_count)
    else $error("wrong number of shift clocks");

  property p_half_code3;
    $rose(sclk_r) && rate_r == 3'h3 |-> sclk_r[*4] ##1 !sclk_r;
  endproperty
  a_half_code3: assert property (p_half_code3)
    else $error("half period wrong at code 3");

  property p_idle_low;
    !busy |-> !sclk_r;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("shift clock not idle");

  property p_set_wins;
    finish && wr_ist && wd_r[0] |=> irq_st_r;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("done event lost to clear");

endmodule

/* File: bench/spm_scan_target.sv */
// Scan target stand-in for the far side of the scan port
`timescale 1ns/1ps
module spm_scan_target (
  input wire logic scan_clk,
  input wire logic scan_mode,
  input wire logic scan_data_out,
  output logic scan_data_in,
  input wire logic scan_drive_n,
  input wire logic restart,
  input wire logic [31:0] reply_word,
  output logic [31:0] mode_seen,
  output logic [31:0] data_seen,
  output logic [31:0] rise_count,
  output logic [31:0] period_ns
);
  logic [5:0] idx_r;
  logic last_r;
  realtime t_rise;
  initial begin
    mode_seen = 32'h0000_0000;
    data_seen = 32'h0000_0000;
    rise_count = 32'h0000_0000;
    period_ns = 32'h0000_0000;
    t_rise = 0.0;
    last_r = 1'b0;
    idx_r = 6'h00;
  end
  // ****************************************
  // Sample on rising edge, LSB arrives first
  // ****************************************
  always @(posedge scan_clk) begin
    mode_seen <= {scan_mode, mode_seen[31:1]};
    data_seen <= {scan_data_out, data_seen[31:1]};
    rise_count <= rise_count + 32'h0000_0001;
    period_ns <= 32'(int'($realtime - t_rise));
    t_rise = $realtime;
  end
  // Reply bit moves on the falling edge
  always @(negedge scan_clk or posedge restart) begin
    if (restart) begin
      idx_r <= 6'h00;
    end else begin
      idx_r <= idx_r + 6'h01;
    end
  end
  always @(posedge scan_drive_n) begin
    last_r = reply_word[idx_r[4:0]];
  end
  // Released line flips so a stale copy never passes
  assign scan_data_in = scan_drive_n ? ~last_r : reply_word[idx_r[4:0]];
endmodule

/* File: bench/spm_shifter_test.sv */
// Register-level bench for the scan port master shifter
`timescale 1ns/1ps
module spm_shifter_test;
  import spm_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, restart;
  logic scan_clk, scan_mode, scan_data_out, scan_data_in, scan_drive_n, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv, reply_word, mode_seen, data_seen;
  logic [31:0] rise_count, period_ns, base;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int bad_count, checked;
  spm_shifter dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scan_clk(scan_clk), .scan_mode(scan_mode),
    .scan_data_out(scan_data_out), .scan_data_in(scan_data_in),
    .scan_drive_n(scan_drive_n), .irq(irq));
  spm_scan_target tgt_u (.scan_clk(scan_clk), .scan_mode(scan_mode),
    .scan_data_out(scan_data_out), .scan_data_in(scan_data_in),
    .scan_drive_n(scan_drive_n), .restart(restart),
    .reply_word(reply_word), .mode_seen(mode_seen), .data_seen(data_seen),
    .rise_count(rise_count), .period_ns(period_ns));
  initial begin
    aclk = 1'b0;
  end
  always #50 aclk = ~aclk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits end by the answer; only the watchdog breaks a hang
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_idle();
    do begin
      bus_rd(OFS_STAT);
    end while (rdv[0] !== 1'b0);
  endtask
  // ****************************************
  // One initiator command at a given rate
  // ****************************************
  task automatic run(input int rate, input int cnt);
    logic [31:0] msk, out_w, mode_w, rep_w;
    msk = (cnt == 31) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (cnt + 1)) - 1);
    out_w = 32'hA5C3_1E69 ^ 32'(rate);
    mode_w = 32'h3C96_F00D + 32'(rate);
    rep_w = 32'h6B1D_4E27 ^ 32'(cnt);
    bus_wr(OFS_CFG, 32'h0000_0008 | 32'(rate));
    bus_wr(OFS_OUT, out_w);
    bus_wr(OFS_MODE, mode_w);
    bus_wr(OFS_CAP, 32'h0000_0000);
    reply_word <= rep_w;
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
    base = rise_count;
    bus_wr(OFS_CMD, 32'(cnt));
    chk("drive_n", 32'(scan_drive_n), 32'h0000_0000);
    bus_rd(OFS_STAT);
    chk("busy", rdv, 32'h0000_0001);
    wait_idle();
    chk("busy_end", rdv, 32'h0000_0000);
    chk("rises", rise_count - base, 32'(cnt + 1));
    chk("period", period_ns, 32'(100 << rate));
    chk("out_bits", data_seen >> (31 - cnt), out_w & msk);
    chk("mode_bits", mode_seen >> (31 - cnt), mode_w & msk);
    // Sync lag hides the reply at the two fastest rates
    if (rate >= 3) begin
      bus_rd(OFS_CAP);
      chk("capture", rdv, rep_w & msk);
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, restart} <= 6'h00;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hF;
    reply_word <= 32'h0000_0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(OFS_CFG);
    chk("cfg_rst", rdv, 32'h0000_0003);
    bus_rd(OFS_CAP);
    chk("cap_rst", rdv, 32'h0000_0000);
    bus_rd(OFS_OUT);
    chk("out_rst", rdv, 32'h0000_0000);
    bus_wr(OFS_OUT, 32'hFFFF_FFFF);
    bus_rd(OFS_OUT);
    chk("out_rw", rdv, 32'hFFFF_FFFF);
    bus_wr(OFS_CAP, 32'h8000_0001);
    bus_rd(OFS_CAP);
    chk("cap_rw", rdv, 32'h8000_0001);
    bus_wr(8'h00, 32'h0000_1234);
    chk("wr_unmapped", 32'(rsp), 32'h0000_0002);
    bus_rd(8'h00);
    chk("rd_unmapped", {rdv[29:0], rsp}, 32'h0000_0002);
    bus_wr(OFS_CFG, 32'h0000_0001);
    base = rise_count;
    bus_wr(OFS_CMD, 32'h0000_0005);
    repeat (20) @(posedge aclk);
    chk("tgt_rises", rise_count - base, 32'h0000_0000);
    chk("tgt_drive_n", 32'(scan_drive_n), 32'h0000_0001);
    bus_rd(OFS_STAT);
    chk("tgt_busy", rdv, 32'h0000_0000);
    for (int r = 1; r <= 7; r++) begin
      run(r, r * 5 - 4);
    end
    // Count zero still gives one shift clock
    bus_wr(OFS_CFG, 32'h0000_0009);
    base = rise_count;
    bus_wr(OFS_CMD, 32'h0000_0000);
    wait_idle();
    chk("one_bit", rise_count - base, 32'h0000_0001);
    // Back to back, the clear lands on the last fall of a two-bit run
    bus_wr(OFS_IRQ_ST, 32'h0000_0001);
    bus_wr(OFS_CMD, 32'h0000_0001);
    bus_wr(OFS_IRQ_ST, 32'h0000_0001);
    bus_rd(OFS_IRQ_ST);
    chk("set_wins", rdv, 32'h0000_0001);
    chk("irq_masked", 32'(irq), 32'h0000_0000);
    bus_rd(OFS_IRQ_ST);
    chk("irq_st", rdv, 32'h0000_0001);
    bus_wr(OFS_IRQ_MSK, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk("irq_on", 32'(irq), 32'h0000_0001);
    bus_wr(OFS_IRQ_ST, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk("irq_off", 32'(irq), 32'h0000_0000);
    bus_rd(OFS_IRQ_ST);
    chk("irq_st_clr", rdv, 32'h0000_0000);
    test_done();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    test_done();
  end
endmodule
